// [core/ivp_top.sv]
// How it works
// - Vectors sit in window FF80h to FFFFh
// - Vector word is handler address for PC
// - Reset sources use FFFEh, priority 63
// - System nonmaskable events use FFFCh, priority 62
// - Second timer flags share FFF2h, priority 57
// - Watchdog interval flag uses FFEEh, priority 55
// - First serial unit flags share FFECh, 54
// - Second serial unit flags share FFEAh, 53
// - Port one pins merge at FFE6h, 51
// - Port two pins merge at FFE4h, 50
`timescale 1ns/1ps
module ivp_top (
  input  logic                      ref_clk,
  input  logic                      rst_n,
  input  logic                      global_int_enable,
  input  logic                      irq_ack,
  input  logic                      brownout_flag,
  input  logic                      supply_supervisor_flag,
  input  logic                      pin_reset_flag,
  input  logic                      watchdog_flag,
  input  logic                      watchdog_interval_mode,
  input  logic                      key_violation_flag,
  input  logic                      software_por_flag,
  input  logic                      software_bor_flag,
  input  logic                      reset_cause_vector,
  input  logic                      freq_lock_loss_flag,
  input  logic                      vacant_access_flag,
  input  logic                      debug_mailbox_in_flag,
  input  logic                      debug_mailbox_out_flag,
  input  logic                      correctable_error_flag,
  input  logic                      uncorrectable_error_flag,
  input  logic                      timer_b_cc1_flag,
  input  logic                      timer_b_cc2_flag,
  input  logic                      timer_b_overflow_flag,
  input  logic [ivp_pkg::SA_W-1:0]  serial_a_flags,
  input  logic                      serial_a_sync_mode,
  input  logic [ivp_pkg::SB_W-1:0]  serial_b_flags,
  input  logic                      serial_b_spi_mode,
  input  logic [7:0]                port_one_change_flags,
  input  logic [7:0]                port_two_change_flags,
  input  logic                      tbl_wr_en,
  input  logic [ivp_pkg::WIDX_W-1:0] tbl_wr_idx,
  input  logic [ivp_pkg::WORD_W-1:0] tbl_wr_data,
  output logic                      irq_req,
  output logic [ivp_pkg::WORD_W-1:0] vector_addr,
  output logic [ivp_pkg::WORD_W-1:0] handler_addr,
  output logic [5:0]                int_priority,
  output logic                      pc_load,
  output logic                      sys_reset_req,
  output logic [ivp_pkg::IDX_W-1:0] timer_b_vector_index,
  output logic [ivp_pkg::IDX_W-1:0] serial_a_vector_index,
  output logic [ivp_pkg::IDX_W-1:0] serial_b_vector_index,
  output logic [ivp_pkg::IDX_W-1:0] port_one_vector_index,
  output logic [ivp_pkg::IDX_W-1:0] port_two_vector_index
);
  import ivp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ivp_state_t        st;
    logic [SLOT_W-1:0] slot;
    logic              irq;
    logic              pc_load;
    logic              sys_rst;
    logic              rd_en;
    logic [WIDX_W-1:0] rd_idx;
    logic [WORD_W-1:0] vec;
    logic [5:0]        pri;
    logic [IDX_W-1:0]  tb_idx;
    logic [IDX_W-1:0]  sa_idx;
    logic [IDX_W-1:0]  sb_idx;
    logic [IDX_W-1:0]  p1_idx;
    logic [IDX_W-1:0]  p2_idx;
  } ivp_ctl_t;

  localparam ivp_ctl_t CTL_RST = ivp_ctl_t'(0);

  ivp_ctl_t          q;
  ivp_ctl_t          d;
  logic [NSLOT-1:0]  pend;
  logic [SLOT_W-1:0] win;
  ivp_vec_if         vif ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Lowest set flag i gives index 2*(i+1), none gives zero
  function automatic logic [IDX_W-1:0] enc_low(input logic [15:0] f);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = 15; i >= 0; i--) begin
      if (f[i]) begin
        r = IDX_W'((i + 1) * 2);
      end
    end
    return r;
  endfunction

  // Lowest slot number is highest priority
  function automatic logic [SLOT_W-1:0] pick(input logic [NSLOT-1:0] p);
    logic [SLOT_W-1:0] r;
    r = '0;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = SLOT_W'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [WIDX_W-1:0] word_idx(input logic [WORD_W-1:0] v);
    logic [WORD_W-1:0] off;
    off = v - VEC_BASE;
    return off[WIDX_W:1];
  endfunction

  // Latch a winner and start the table read
  function automatic ivp_ctl_t launch(input ivp_ctl_t c, input logic [SLOT_W-1:0] w);
    ivp_ctl_t r;
    r        = c;
    r.slot   = w;
    r.vec    = SLOT_VEC[w];
    r.pri    = SLOT_PRI[w];
    r.rd_idx = word_idx(SLOT_VEC[w]);
    r.rd_en  = 1'b1;
    r.st     = ST_READ;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Source merge
  // ----------------------------------------------------------------
  always_comb begin
    pend         = '0;
    pend[SL_RST] = brownout_flag | supply_supervisor_flag | pin_reset_flag
                 | (watchdog_flag & ~watchdog_interval_mode) | key_violation_flag
                 | software_por_flag | software_bor_flag | reset_cause_vector
                 | freq_lock_loss_flag;
    pend[SL_NMI] = vacant_access_flag | debug_mailbox_in_flag | debug_mailbox_out_flag
                 | correctable_error_flag | uncorrectable_error_flag;
    pend[SL_TMB] = global_int_enable
                 & (timer_b_cc1_flag | timer_b_cc2_flag | timer_b_overflow_flag);
    pend[SL_WDT] = global_int_enable & watchdog_flag & watchdog_interval_mode;
    pend[SL_SA]  = global_int_enable & (|(serial_a_flags
                 & (serial_a_sync_mode ? SA_SYNC_MSK : SA_ASYN_MSK)));
    pend[SL_SB]  = global_int_enable & (|(serial_b_flags
                 & (serial_b_spi_mode ? SB_SPI_MSK : SB_I2C_MSK)));
    pend[SL_P1]  = global_int_enable & (|port_one_change_flags);
    pend[SL_P2]  = global_int_enable & (|port_two_change_flags);
    win          = pick(pend);
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d         = q;
    d.pc_load = 1'b0;
    d.rd_en   = 1'b0;
    d.sys_rst = pend[SL_RST];
    d.tb_idx  = enc_low({13'h0000, timer_b_overflow_flag, timer_b_cc2_flag,
                         timer_b_cc1_flag});
    d.sa_idx  = enc_low({12'h000,
                         serial_a_flags & (serial_a_sync_mode ? SA_SYNC_MSK : SA_ASYN_MSK)});
    d.sb_idx  = enc_low({2'h0,
                         serial_b_flags & (serial_b_spi_mode ? SB_SPI_MSK : SB_I2C_MSK)});
    d.p1_idx  = enc_low({8'h00, port_one_change_flags});
    d.p2_idx  = enc_low({8'h00, port_two_change_flags});
    case (q.st)
      ST_IDLE: begin
        if (|pend) begin
          d = launch(d, win);
        end
      end
      ST_READ: begin
        if (!pend[q.slot]) begin
          d.st = ST_IDLE;
        end else begin
          d.st  = ST_OFFER;
          d.irq = 1'b1;
        end
      end
      ST_OFFER: begin
        if (!pend[q.slot] || (win < q.slot)) begin
          d.irq = 1'b0;
          if (|pend) begin
            d = launch(d, win);
          end else begin
            d.st = ST_IDLE;
          end
        end else if (irq_ack) begin
          d.irq     = 1'b0;
          d.pc_load = 1'b1;
          d.st      = ST_LOAD;
        end
      end
      ST_LOAD: begin
        d.st = ST_IDLE;
      end
      default: begin
        d = CTL_RST;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= CTL_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Handler table
  // ----------------------------------------------------------------
  assign vif.wr_en   = tbl_wr_en;
  assign vif.wr_idx  = tbl_wr_idx;
  assign vif.wr_data = tbl_wr_data;
  assign vif.rd_en   = q.rd_en;
  assign vif.rd_idx  = q.rd_idx;

  ivp_vec_mem u_mem (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .vif     (vif)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign irq_req               = q.irq;
  assign vector_addr           = q.vec;
  assign handler_addr          = vif.rd_data;
  assign int_priority          = q.pri;
  assign pc_load               = q.pc_load;
  assign sys_reset_req         = q.sys_rst;
  assign timer_b_vector_index  = q.tb_idx;
  assign serial_a_vector_index = q.sa_idx;
  assign serial_b_vector_index = q.sb_idx;
  assign port_one_vector_index = q.p1_idx;
  assign port_two_vector_index = q.p2_idx;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Winner latched in idle, still pending through the table read
  sequence s_launch(logic [2:0] s);
    (q.st == ST_IDLE && win == s && pend[s]) ##1 pend[s];
  endsequence

  sequence s_offer(logic [15:0] v, logic [5:0] p);
    ##1 (irq_req && vector_addr == v && int_priority == p);
  endsequence

  a_vec_window: assert property (
    irq_req |-> (vector_addr >= VEC_BASE && vector_addr <= VEC_TOP && !vector_addr[0]))
    else $error("vector outside window");
  a_handler_load: assert property (
    (q.st == ST_OFFER && irq_ack && pend[q.slot] && !(win < q.slot))
      |=> (pc_load && !irq_req && $stable(handler_addr)) ##1 !pc_load)
    else $error("handler load pulse wrong");
  a_reset_top: assert property (
    s_launch(SL_RST) |-> s_offer(VEC_RST, PRI_RST))
    else $error("reset vector wrong");
  a_nmi_bypass: assert property (
    (!global_int_enable ##0 s_launch(SL_NMI)) |-> s_offer(VEC_NMI, PRI_NMI))
    else $error("nonmaskable vector wrong");
  a_timer_vec: assert property (
    s_launch(SL_TMB) |-> s_offer(VEC_TMB, PRI_TMB))
    else $error("timer vector wrong");
  a_wdt_vec: assert property (
    s_launch(SL_WDT) |-> s_offer(VEC_WDT, PRI_WDT))
    else $error("watchdog interval vector wrong");
  a_sa_vec: assert property (
    s_launch(SL_SA) |-> s_offer(VEC_SA, PRI_SA))
    else $error("first serial vector wrong");
  a_sb_vec: assert property (
    s_launch(SL_SB) |-> s_offer(VEC_SB, PRI_SB))
    else $error("second serial vector wrong");
  a_port_one_map: assert property (
    (s_launch(SL_P1) |-> s_offer(VEC_P1, PRI_P1))
    and (port_one_change_flags[0] |=> port_one_vector_index == IDX_W'(2)))
    else $error("port one vector wrong");
  a_port_two_map: assert property (
    (s_launch(SL_P2) |-> s_offer(VEC_P2, PRI_P2))
    and (port_two_change_flags[0] |=> port_two_vector_index == IDX_W'(2)))
    else $error("port two vector wrong");
  a_preempt_win: assert property (
    (q.st == ST_OFFER && pend[q.slot] && win < q.slot)
      |=> (!irq_req && q.st == ST_READ && q.slot == $past(win)))
    else $error("higher priority not taken");
  a_gie_gate: assert property (
    (irq_req && int_priority < PRI_NMI) |-> $past(global_int_enable))
    else $error("maskable offered without enable");
endmodule

// [core/ivp_vec_mem.sv]
`timescale 1ns/1ps
module ivp_vec_mem (
  input  logic   ref_clk,
  input  logic   rst_n,
  ivp_vec_if.mem vif
);
  import ivp_pkg::*;

  // ----------------------------------------------------------------
  // Handler word table over the vector window
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] words [0:(1<<WIDX_W)-1];
  logic [WORD_W-1:0] rd_q;

  always_ff @(posedge ref_clk) begin
    if (vif.wr_en) begin
      words[vif.wr_idx] <= vif.wr_data;
    end
  end

  // Read data held until the next read
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_q <= '0;
    end else if (vif.rd_en) begin
      rd_q <= words[vif.rd_idx];
    end
  end

  assign vif.rd_data = rd_q;
endmodule

// [shared/ivp_pkg.sv]
package ivp_pkg;

  // ----------------------------------------------------------------
  // Vector window
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_BASE  = 16'hff80;
  localparam logic [15:0] VEC_TOP   = 16'hffff;
  localparam int          WORD_W    = 16;
  localparam int          WIDX_W    = 6;
  localparam int          IDX_W     = 8;
  localparam int          NSLOT     = 8;
  localparam int          SLOT_W    = 3;

  // ----------------------------------------------------------------
  // Source slots, highest priority first
  // ----------------------------------------------------------------
  localparam logic [2:0] SL_RST = 3'h0;
  localparam logic [2:0] SL_NMI = 3'h1;
  localparam logic [2:0] SL_TMB = 3'h2;
  localparam logic [2:0] SL_WDT = 3'h3;
  localparam logic [2:0] SL_SA  = 3'h4;
  localparam logic [2:0] SL_SB  = 3'h5;
  localparam logic [2:0] SL_P1  = 3'h6;
  localparam logic [2:0] SL_P2  = 3'h7;

  localparam logic [15:0] VEC_RST = 16'hfffe;
  localparam logic [15:0] VEC_NMI = 16'hfffc;
  localparam logic [15:0] VEC_TMB = 16'hfff2;
  localparam logic [15:0] VEC_WDT = 16'hffee;
  localparam logic [15:0] VEC_SA  = 16'hffec;
  localparam logic [15:0] VEC_SB  = 16'hffea;
  localparam logic [15:0] VEC_P1  = 16'hffe6;
  localparam logic [15:0] VEC_P2  = 16'hffe4;

  localparam logic [5:0] PRI_RST = 6'h3f;
  localparam logic [5:0] PRI_NMI = 6'h3e;
  localparam logic [5:0] PRI_TMB = 6'h39;
  localparam logic [5:0] PRI_WDT = 6'h37;
  localparam logic [5:0] PRI_SA  = 6'h36;
  localparam logic [5:0] PRI_SB  = 6'h35;
  localparam logic [5:0] PRI_P1  = 6'h33;
  localparam logic [5:0] PRI_P2  = 6'h32;

  localparam logic [15:0] SLOT_VEC [0:NSLOT-1] =
    '{VEC_RST, VEC_NMI, VEC_TMB, VEC_WDT, VEC_SA, VEC_SB, VEC_P1, VEC_P2};
  localparam logic [5:0] SLOT_PRI [0:NSLOT-1] =
    '{PRI_RST, PRI_NMI, PRI_TMB, PRI_WDT, PRI_SA, PRI_SB, PRI_P1, PRI_P2};

  // ----------------------------------------------------------------
  // Serial flag layouts
  // ----------------------------------------------------------------
  localparam int         SA_W        = 4;     // rx, tx, tx_complete, start_seen
  localparam logic [3:0] SA_SYNC_MSK = 4'h3;
  localparam logic [3:0] SA_ASYN_MSK = 4'hf;
  localparam int         SB_W        = 14;    // rx0 tx0 .. rx3 tx3, al, nack, stt, stp, cnt, bit9
  localparam logic [13:0] SB_SPI_MSK = 14'h0003;
  localparam logic [13:0] SB_I2C_MSK = 14'h3fff;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_OFFER = 2'h3,
    ST_LOAD  = 2'h2
  } ivp_state_t;

endpackage

// [shared/ivp_vec_if.sv]
`timescale 1ns/1ps
interface ivp_vec_if;
  import ivp_pkg::*;
  logic              wr_en;
  logic [WIDX_W-1:0] wr_idx;
  logic [WORD_W-1:0] wr_data;
  logic              rd_en;
  logic [WIDX_W-1:0] rd_idx;
  logic [WORD_W-1:0] rd_data;

  modport ctrl (output wr_en, output wr_idx, output wr_data,
                output rd_en, output rd_idx, input rd_data);
  modport mem  (input wr_en, input wr_idx, input wr_data,
                input rd_en, input rd_idx, output rd_data);
endinterface

// [tb/ivp_cpu_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// CPU side: acks an offer after a set wait, loads the handler
// ------------------------------------------------------------
module ivp_cpu_model (
  input  logic                       ref_clk,
  input  logic                       rst_n,
  input  logic [3:0]                 ack_dly,
  input  logic                       irq_req,
  input  logic                       pc_load,
  input  logic [ivp_pkg::WORD_W-1:0] handler_addr,
  output logic                       irq_ack,
  output logic [ivp_pkg::WORD_W-1:0] pc_value
);
  import ivp_pkg::*;
  logic [3:0] wait_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wait_q <= 4'h0;
      irq_ack <= 1'b0;
      pc_value <= '0;
    end else begin
      wait_q <= irq_req ? wait_q + 4'h1 : 4'h0;
      // Ack held for one edge only, dropped with a withdrawn offer
      irq_ack <= irq_req && !irq_ack && (wait_q >= ack_dly);
      if (pc_load) begin
        pc_value <= handler_addr;
      end
    end
  end
endmodule

// [tb/ivp_top_tb.sv]
`timescale 1ns/1ps
module ivp_top_tb;
  import ivp_pkg::*;
  logic        ref_clk;
  logic        rst_n;
  logic        gie;
  logic        irq_ack;
  logic [3:0]  ack_dly;
  logic [8:0]  rst_f;
  logic [4:0]  nmi_f;
  logic [2:0]  tmb_f;
  logic        wdt_f;
  logic [3:0]  sa_f;
  logic        sa_sync;
  logic [13:0] sb_f;
  logic        sb_spi;
  logic [7:0]  p1_f;
  logic [7:0]  p2_f;
  logic        wr_en;
  logic [5:0]  wr_idx;
  logic [15:0] wr_data;
  logic        irq_req;
  logic        pc_load;
  logic        sys_reset_req;
  logic [15:0] vector_addr;
  logic [15:0] handler_addr;
  logic [15:0] pc_value;
  logic [15:0] cap_v;
  logic [15:0] cap_h;
  logic [5:0]  int_priority;
  logic [5:0]  cap_p;
  logic [7:0]  ix_tb;
  logic [7:0]  ix_sa;
  logic [7:0]  ix_sb;
  logic [7:0]  ix_p1;
  logic [7:0]  ix_p2;
  logic [15:0] hnd [8];
  logic [31:0] rnd;
  int          exp_q [$];
  int          mon_slot;
  int          err_count;
  int          total_checks;
  int          cyc;
  localparam logic [15:0] EXP_VEC [8] = '{16'hfffe, 16'hfffc, 16'hfff2, 16'hffee,
                                          16'hffec, 16'hffea, 16'hffe6, 16'hffe4};
  localparam logic [5:0]  EXP_PRI [8] = '{6'h3f, 6'h3e, 6'h39, 6'h37,
                                          6'h36, 6'h35, 6'h33, 6'h32};

  ivp_top i_ivp_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .global_int_enable(gie), .irq_ack(irq_ack),
    .brownout_flag(rst_f[0]), .supply_supervisor_flag(rst_f[1]),
    .pin_reset_flag(rst_f[2]), .watchdog_flag(rst_f[3] | wdt_f),
    .watchdog_interval_mode(!rst_f[3]), .key_violation_flag(rst_f[4]),
    .software_por_flag(rst_f[5]), .software_bor_flag(rst_f[6]),
    .reset_cause_vector(rst_f[7]), .freq_lock_loss_flag(rst_f[8]),
    .vacant_access_flag(nmi_f[0]), .debug_mailbox_in_flag(nmi_f[1]),
    .debug_mailbox_out_flag(nmi_f[2]), .correctable_error_flag(nmi_f[3]),
    .uncorrectable_error_flag(nmi_f[4]), .timer_b_cc1_flag(tmb_f[0]),
    .timer_b_cc2_flag(tmb_f[1]), .timer_b_overflow_flag(tmb_f[2]),
    .serial_a_flags(sa_f), .serial_a_sync_mode(sa_sync), .serial_b_flags(sb_f),
    .serial_b_spi_mode(sb_spi), .port_one_change_flags(p1_f),
    .port_two_change_flags(p2_f), .tbl_wr_en(wr_en), .tbl_wr_idx(wr_idx),
    .tbl_wr_data(wr_data), .irq_req(irq_req), .vector_addr(vector_addr),
    .handler_addr(handler_addr), .int_priority(int_priority), .pc_load(pc_load),
    .sys_reset_req(sys_reset_req), .timer_b_vector_index(ix_tb),
    .serial_a_vector_index(ix_sa), .serial_b_vector_index(ix_sb),
    .port_one_vector_index(ix_p1), .port_two_vector_index(ix_p2)
  );

  ivp_cpu_model i_ivp_cpu_model (
    .ref_clk(ref_clk), .rst_n(rst_n), .ack_dly(ack_dly), .irq_req(irq_req),
    .pc_load(pc_load), .handler_addr(handler_addr), .irq_ack(irq_ack),
    .pc_value(pc_value)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic [15:0] low_idx(input logic [13:0] f);
    for (int i = 0; i < 14; i++) begin
      if (f[i]) return 16'(2 * (i + 1));
    end
    return 16'h0000;
  endfunction

  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Source flags, one flag per slot picked by k modulo the group width
  // ------------------------------------------------------------
  task setf(input int s, input logic on, input int k);
    case (s)
      0: rst_f[k % 9] = on;
      1: nmi_f[k % 5] = on;
      2: tmb_f[k % 3] = on;
      3: wdt_f = on;
      4: sa_f[k % 4] = on;
      5: sb_f[k % 14] = on;
      6: p1_f[k % 8] = on;
      default: p2_f[k % 8] = on;
    endcase
  endtask

  task serve(input int s, input int k);
    for (int n = 0; n < 60 && pc_load !== 1'b1; n++) @(negedge ref_clk);
    chk({15'h0, pc_load}, 16'h0001);
    chk({15'h0, sys_reset_req}, {15'h0, s == 0});
    setf(s, 1'b0, k);
    @(negedge ref_clk);
    chk(pc_value, hnd[s]);
  endtask

  // ------------------------------------------------------------
  // Monitor: each load is matched with the oldest expected slot
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
    if (rst_n && irq_req && irq_ack) begin
      cap_v <= vector_addr;
      cap_p <= int_priority;
      cap_h <= handler_addr;
    end
    if (rst_n && pc_load) begin
      if (exp_q.size() == 0) chk(cap_v, 16'h0000);
      else begin
        mon_slot = exp_q.pop_front();
        chk(cap_v, EXP_VEC[mon_slot]);
        chk({10'h0, cap_p}, {10'h0, EXP_PRI[mon_slot]});
        chk(cap_h, hnd[mon_slot]);
      end
    end
  end

  initial begin
    rnd = 32'h0976;
    {rst_n, gie, ack_dly, rst_f, nmi_f, tmb_f, wdt_f} = '0;
    {sa_f, sa_sync, sb_f, sb_spi, p1_f, p2_f, wr_en, wr_idx, wr_data} = '0;
    {err_count, total_checks, cyc} = '0;
    gie = 1'b1;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    for (int s = 0; s < 8; s++) begin
      rnd = xs(rnd);
      hnd[s] = rnd[15:0];
      wr_en = 1'b1;
      wr_idx = 6'((EXP_VEC[s] - 16'hff80) >> 1);
      wr_data = rnd[15:0];
      @(negedge ref_clk);
    end
    wr_en = 1'b0;
    @(negedge ref_clk);
    for (int s = 0; s < 8; s++) begin
      for (int k = 0; k < 9; k++) begin
        ack_dly = 4'(k % 3);
        exp_q.push_back(s);
        setf(s, 1'b1, k);
        serve(s, k);
      end
    end
    for (int s = 0; s < 8; s++) begin
      exp_q.push_back(s);
      setf(s, 1'b1, 0);
    end
    for (int s = 0; s < 8; s++) serve(s, 0);
    gie = 1'b0;
    setf(7, 1'b1, 2);
    repeat (10) begin
      @(negedge ref_clk);
      chk({15'h0, irq_req}, 16'h0000);
    end
    exp_q.push_back(1);
    exp_q.push_back(7);
    setf(1, 1'b1, 4);
    serve(1, 4);
    gie = 1'b1;
    serve(7, 2);
    ack_dly = 4'h8;
    exp_q.push_back(1);
    exp_q.push_back(6);
    setf(6, 1'b1, 5);
    for (int n = 0; n < 20 && irq_req !== 1'b1; n++) @(negedge ref_clk);
    chk({10'h0, int_priority}, 16'h0033);
    setf(1, 1'b1, 0);
    serve(1, 0);
    serve(6, 5);
    sa_sync = 1'b1;
    sa_f = 4'h4;
    sb_spi = 1'b1;
    sb_f = 14'h0100;
    repeat (6) begin
      @(negedge ref_clk);
      chk({15'h0, irq_req}, 16'h0000);
    end
    {sa_f, sb_f} = '0;
    ack_dly = 4'h0;
    gie = 1'b0;
    repeat (24) begin
      rnd = xs(rnd);
      {sb_f, sa_f, p2_f, p1_f} = {rnd[1:0], rnd};
      tmb_f = rnd[31:29];
      sa_sync = rnd[3];
      sb_spi = rnd[12];
      repeat (2) @(negedge ref_clk);
      chk({8'h00, ix_tb}, low_idx(14'(tmb_f)));
      chk({8'h00, ix_sa}, low_idx(14'(sa_sync ? sa_f & 4'h3 : sa_f)));
      chk({8'h00, ix_sb}, low_idx(sb_spi ? sb_f & 14'h0003 : sb_f));
      chk({8'h00, ix_p1}, low_idx(14'(p1_f)));
      chk({8'h00, ix_p2}, low_idx(14'(p2_f)));
    end
    {tmb_f, sa_f, sb_f, p1_f, p2_f} = '0;
    repeat (4) @(negedge ref_clk);
    final_report();
  end
endmodule
